/* rps_pkg.sv */
// rps_pkg: constants and types for the radio subsystem power mode controller
// assumes a single 250 MHz system clock domain
package rps_pkg;
  // ---------------------------------------------------------------
  // subsystem modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RPS_DSLEEP = 3'h0,
    RPS_SLEEP  = 3'h1,
    RPS_IDLE   = 3'h2,
    RPS_TX     = 3'h3,
    RPS_RX     = 3'h4,
    RPS_OFF    = 3'h5
  } rps_mode_e;

  // chip-level power modes
  typedef enum logic [2:0] {
    RPS_CHIP_ACT   = 3'h0,
    RPS_CHIP_LPACT = 3'h1,
    RPS_CHIP_SLP   = 3'h2,
    RPS_CHIP_LPSLP = 3'h3,
    RPS_CHIP_DSLP  = 3'h4,
    RPS_CHIP_HIB   = 3'h5
  } rps_chip_e;

  // ---------------------------------------------------------------
  // rates, connection limit and reset mode
  // ---------------------------------------------------------------
  localparam int RPS_CLK_MHZ     = 250;
  localparam int RPS_TX_KBPS     = 2000;
  localparam int RPS_RX_KBPS     = 1000;
  localparam int RPS_TX_DIV      = (RPS_CLK_MHZ * 1000) / RPS_TX_KBPS;
  localparam int RPS_RX_DIV      = (RPS_CLK_MHZ * 1000) / RPS_RX_KBPS;
  localparam int RPS_MAX_CONN    = 4;
  localparam logic [2:0] RPS_RESET_MODE = 3'h0;
endpackage

/* rps_ctrl.sv */
// rps_ctrl: power mode sequencer for the radio subsystem
// assumes firmware request pulses and pins synchronous to sys_clk except chip mode
`timescale 1ns/1ps
module rps_ctrl #(
  parameter int TX_DIV = rps_pkg::RPS_TX_DIV,
  parameter int RX_DIV = rps_pkg::RPS_RX_DIV
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  // firmware request
  input  wire logic                req_valid,
  input  wire rps_pkg::rps_mode_e  req_mode,
  input  wire logic [2:0]          conn_req,
  // chip power mode, asynchronous
  input  wire logic [2:0]          chip_mode,
  // link layer datapath
  input  wire logic                tx_bit,
  input  wire logic                pkt_busy,
  output logic                     tx_bit_ready,
  output logic                     phy_tx_data,
  output logic                     phy_tx_strobe,
  input  wire logic                phy_rx_data,
  output logic                     ll_rx_data,
  output logic                     ll_rx_strobe,
  // gating outputs
  output logic                     high_freq_crystal_osc_en,
  output logic                     watch_osc_en,
  output logic                     radio_tx_en,
  output logic                     radio_rx_en,
  output logic                     core_clk_en,
  output logic                     ll_clk_en,
  output logic                     crypto_hw_en,
  output logic                     gpio_freeze,
  output logic                     ctx_retain,
  output logic                     wake_reset,
  output logic [2:0]               conn_limit,
  output rps_pkg::rps_mode_e       cur_mode
);
  import rps_pkg::*;

  // the serial dividers are 16 bits wide and need at least two states
  if (TX_DIV < 2 || RX_DIV < 2 || TX_DIV > 65535 || RX_DIV > 65535) begin : g_div_chk
    $error("rps_ctrl: divider out of range");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    rps_mode_e   mode;
    rps_mode_e   pend;
    logic        pend_v;
    logic [2:0]  cs1;
    logic [2:0]  cs2;
    logic [2:0]  cs3;
    logic [2:0]  chip;
    logic        hib_seen;
    logic        wrst;
    logic [15:0] txc;
    logic [15:0] rxc;
    logic        txd;
    logic        txs;
    logic        rxd;
    logic        rxs;
    logic [2:0]  conn;
    logic [6:0]  outs;
  } rps_state_s;

  rps_state_s st_r;
  rps_state_s st_nxt;

  // legal transition check
  function automatic logic legal(input rps_mode_e f, input rps_mode_e t);
    case (t)
      RPS_TX:     legal = (f == RPS_IDLE);
      RPS_RX:     legal = (f == RPS_IDLE);
      RPS_IDLE,
      RPS_SLEEP,
      RPS_DSLEEP: legal = (f != RPS_OFF);
      default:    legal = 1'b0;
    endcase
  endfunction

  // mode to enables {hfx, wco, tx, rx, core, ll, crypto}
  function automatic logic [6:0] gates(input rps_mode_e m);
    case (m)
      RPS_DSLEEP: gates = 7'h20;
      RPS_SLEEP:  gates = 7'h60;
      RPS_IDLE:   gates = 7'h67;
      RPS_TX:     gates = 7'h77;
      RPS_RX:     gates = 7'h6f;
      default:    gates = 7'h00;
    endcase
  endfunction

  logic [2:0] chip_s;
  logic       hib;
  logic       retain;
  assign chip_s = st_r.chip;
  assign hib    = (chip_s == RPS_CHIP_HIB);
  assign retain = (chip_s == RPS_CHIP_DSLP);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.cs1  = chip_mode;
    st_nxt.cs2  = st_r.cs1;
    st_nxt.cs3  = st_r.cs2;
    if (st_r.cs2 == st_r.cs3) begin
      st_nxt.chip = st_r.cs3;
    end
    st_nxt.wrst = 1'b0;
    st_nxt.txs  = 1'b0;
    st_nxt.rxs  = 1'b0;
    if (hib) begin
      st_nxt.hib_seen = 1'b1;
      st_nxt.mode     = RPS_OFF;
      st_nxt.pend_v   = 1'b0;
    end else if (st_r.hib_seen) begin
      st_nxt.hib_seen = 1'b0;
      st_nxt.wrst     = 1'b1;
      st_nxt.mode     = RPS_DSLEEP;
    end else if (!retain) begin
      if (st_r.pend_v && !pkt_busy) begin
        st_nxt.mode   = st_r.pend;
        st_nxt.pend_v = 1'b0;
      end
      // judged against the mode in force next cycle, so a request that lands
      // as a pending one retires is kept and cannot skip the idle step
      if (req_valid && legal(st_nxt.mode, req_mode)) begin
        st_nxt.pend   = req_mode;
        st_nxt.pend_v = 1'b1;
        st_nxt.conn   = (conn_req > 3'(RPS_MAX_CONN)) ? 3'(RPS_MAX_CONN) : conn_req;
      end
    end
    st_nxt.outs = hib ? 7'h00 : gates(st_nxt.mode);
    // serial rates
    if (st_r.mode == RPS_TX) begin
      if (st_r.txc == 16'(TX_DIV - 1)) begin
        st_nxt.txc = 16'h0000;
        st_nxt.txd = tx_bit;
        st_nxt.txs = 1'b1;
      end else begin
        st_nxt.txc = st_r.txc + 16'h0001;
      end
    end else begin
      st_nxt.txc = 16'h0000;
    end
    if (st_r.mode == RPS_RX) begin
      if (st_r.rxc == 16'(RX_DIV - 1)) begin
        st_nxt.rxc = 16'h0000;
        st_nxt.rxd = phy_rx_data;
        st_nxt.rxs = 1'b1;
      end else begin
        st_nxt.rxc = st_r.rxc + 16'h0001;
      end
    end else begin
      st_nxt.rxc = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cur_mode                 = st_r.mode;
  assign high_freq_crystal_osc_en = st_r.outs[6];
  assign watch_osc_en             = st_r.outs[5];
  assign radio_tx_en              = st_r.outs[4];
  assign radio_rx_en              = st_r.outs[3];
  assign core_clk_en              = st_r.outs[2];
  assign ll_clk_en                = st_r.outs[1];
  assign crypto_hw_en             = st_r.outs[0];
  assign gpio_freeze              = st_r.hib_seen;
  assign ctx_retain               = retain;
  assign wake_reset               = st_r.wrst;
  assign conn_limit               = st_r.conn;
  assign phy_tx_data              = st_r.txd;
  assign phy_tx_strobe            = st_r.txs;
  assign ll_rx_data               = st_r.rxd;
  assign ll_rx_strobe             = st_r.rxs;
  assign tx_bit_ready             = (st_r.mode == RPS_TX) && (st_r.txc == 16'(TX_DIV - 1));

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence tx_req_s;
    req_valid && req_mode == RPS_TX;
  endsequence

  // leaving hibernate: one-cycle wake reset in the first cycle of deep sleep
  sequence hib_exit_s;
    st_r.hib_seen && !hib;
  endsequence

  sequence wake_pulse_s;
    wake_reset && cur_mode == RPS_DSLEEP ##1 !wake_reset;
  endsequence

  // a pending mode that nothing holds back
  sequence pend_due_s;
    st_r.pend_v && !pkt_busy && !hib && !st_r.hib_seen && !retain;
  endsequence

  // divider wrap in each stream direction
  sequence tx_take_s;
    tx_bit_ready;
  endsequence

  sequence rx_take_s;
    st_r.mode == RPS_RX && st_r.rxc == 16'(RX_DIV - 1);
  endsequence

  tx_from_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $changed(st_r.mode) && st_r.mode == RPS_TX |-> $past(st_r.mode) == RPS_IDLE)
    else $error("transmit entered from non-idle");
  bad_req_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_req_s and (st_r.mode == RPS_SLEEP) and !st_r.pend_v and !hib and !st_r.hib_seen
    |=> st_r.mode == RPS_SLEEP)
    else $error("illegal request changed mode");
  dsleep_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.mode == RPS_DSLEEP ##1 st_r.mode == RPS_DSLEEP |-> !radio_tx_en && !radio_rx_en
    && !core_clk_en && watch_osc_en)
    else $error("deep sleep gating wrong");
  sleep_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(st_r.mode) == RPS_SLEEP && st_r.mode == RPS_SLEEP && !hib |->
    high_freq_crystal_osc_en && !core_clk_en && !radio_tx_en)
    else $error("sleep gating wrong");
  idle_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(st_r.mode) == RPS_IDLE && st_r.mode == RPS_IDLE && !hib |-> ll_clk_en && !radio_tx_en)
    else $error("idle gating wrong");
  rx_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(st_r.mode) == RPS_RX && st_r.mode == RPS_RX && !hib |-> radio_rx_en && !radio_tx_en)
    else $error("receive gating wrong");
  busy_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pkt_busy && !hib && !st_r.hib_seen |=> st_r.mode == $past(st_r.mode))
    else $error("mode changed during packet");
  hib_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hib |=> st_r.mode == RPS_OFF && gpio_freeze)
    else $error("hibernate did not switch off");
  conn_max_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    conn_limit <= 3'(RPS_MAX_CONN))
    else $error("connection limit exceeded");
  tx_rate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    phy_tx_strobe |=> !phy_tx_strobe)
    else $error("tx strobe too fast");

  // ---------------------------------------------------------------
  // mode and chip checks
  // ---------------------------------------------------------------
  tx_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.mode == RPS_TX |-> high_freq_crystal_osc_en && radio_tx_en && !radio_rx_en
    && core_clk_en && ll_clk_en)
    else $error("transmit gating wrong");
  off_gates_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.mode == RPS_OFF |-> !watch_osc_en && !radio_tx_en && !radio_rx_en && !core_clk_en)
    else $error("off mode gating wrong");
  path_excl_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(radio_tx_en && radio_rx_en))
    else $error("both radio paths on");
  retain_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    retain && !st_r.hib_seen |=> $stable(st_r.mode))
    else $error("mode changed in chip deep sleep");
  sync_agree_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $changed(st_r.chip) |-> $past(st_r.cs2) == $past(st_r.cs3))
    else $error("chip mode taken before settling");
  pend_apply_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pend_due_s |=> st_r.mode == $past(st_r.pend))
    else $error("pending mode not applied");
  wake_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hib_exit_s |=> wake_pulse_s)
    else $error("wake reset pulse wrong");
  wake_src_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wake_reset |-> $past(st_r.hib_seen))
    else $error("wake reset without hibernate");
  freeze_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    gpio_freeze |-> st_r.mode == RPS_OFF)
    else $error("pins frozen outside hibernate");

  // ---------------------------------------------------------------
  // stream checks
  // ---------------------------------------------------------------
  tx_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_take_s |=> phy_tx_strobe && phy_tx_data == $past(tx_bit))
    else $error("transmit bit not passed");
  rx_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_take_s |=> ll_rx_strobe && ll_rx_data == $past(phy_rx_data))
    else $error("receive bit not passed");
  rx_rate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ll_rx_strobe |=> !ll_rx_strobe)
    else $error("rx strobe too fast");
  tx_src_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    phy_tx_strobe |-> $past(st_r.mode) == RPS_TX)
    else $error("tx strobe outside transmit");
  rx_src_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ll_rx_strobe |-> $past(st_r.mode) == RPS_RX)
    else $error("rx strobe outside receive");
  div_bound_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_r.txc < 16'(TX_DIV) && st_r.rxc < 16'(RX_DIV))
    else $error("divider count out of range");
endmodule

/* rps_ll_model.sv */
// rps_ll_model: link layer and phy stand-in facing rps_ctrl
// assumes the same sys_clk and arst_n as the controller
`timescale 1ns/1ps
module rps_ll_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // stream side
  input  wire logic tx_bit_ready,
  input  wire logic busy_req,
  output logic      tx_bit,
  output logic      pkt_busy,
  output logic      phy_rx_data
);
  logic [7:0] pat_r;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pat_r       <= 8'h5c;
      phy_rx_data <= 1'b0;
    end else begin
      // next bit only after the current one was taken
      if (tx_bit_ready) begin
        pat_r <= {pat_r[6:0], pat_r[7]};
      end
      // air data toggles each cycle while pat_r[3] is low and holds while it is high
      phy_rx_data <= ~phy_rx_data ^ pat_r[3];
    end
  end

  assign tx_bit   = pat_r[7];
  assign pkt_busy = busy_req;
endmodule

/* rps_ctrl_test.sv */
// rps_ctrl_test: self-checking bench for the power mode controller
// assumes rps_pkg and rps_ll_model are compiled first
`timescale 1ns/1ps
module rps_ctrl_test;
  import rps_pkg::*;
  localparam int TXD = 5;
  localparam int RXD = 8;
  logic       sys_clk   = 1'b0;
  logic       arst_n    = 1'b0;
  logic       req_valid = 1'b0;
  rps_mode_e  req_mode  = RPS_DSLEEP;
  logic [2:0] conn_req  = 3'h0;
  logic [2:0] chip_mode = 3'h0;
  logic       busy_req  = 1'b0;
  logic       tx_bit, pkt_busy, tx_bit_ready, phy_tx_data, phy_tx_strobe, phy_rx_data;
  logic       ll_rx_data, ll_rx_strobe, hfx, wco, rtx, rrx, core, llc, cry, frz, ret, wrst;
  logic [2:0] conn_limit;
  rps_mode_e  cur_mode;
  int         errors   = 0;
  int         compares = 0;
  int         cyc      = 0;
  int         n;

  rps_ctrl #(.TX_DIV(TXD), .RX_DIV(RXD)) u_rps_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req_mode(req_mode),
    .conn_req(conn_req), .chip_mode(chip_mode), .tx_bit(tx_bit), .pkt_busy(pkt_busy),
    .tx_bit_ready(tx_bit_ready), .phy_tx_data(phy_tx_data), .phy_tx_strobe(phy_tx_strobe),
    .phy_rx_data(phy_rx_data), .ll_rx_data(ll_rx_data), .ll_rx_strobe(ll_rx_strobe),
    .high_freq_crystal_osc_en(hfx), .watch_osc_en(wco), .radio_tx_en(rtx),
    .radio_rx_en(rrx), .core_clk_en(core), .ll_clk_en(llc), .crypto_hw_en(cry),
    .gpio_freeze(frz), .ctx_retain(ret), .wake_reset(wrst), .conn_limit(conn_limit),
    .cur_mode(cur_mode));

  rps_ll_model u_rps_ll_model (
    .sys_clk(sys_clk), .arst_n(arst_n), .tx_bit_ready(tx_bit_ready),
    .busy_req(busy_req), .tx_bit(tx_bit), .pkt_busy(pkt_busy), .phy_rx_data(phy_rx_data));

  always #2 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic results();
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_mode(input rps_mode_e exp);
    compares++;
    if (cur_mode !== exp) begin
      errors++;
      $display("MISMATCH cur_mode expected %0d seen %0d", exp, cur_mode);
    end
  endtask

  // gate order: hfx, watch, tx, rx, core, link layer, crypto
  function automatic logic [7:0] gates();
    return {1'b0, hfx, wco, rtx, rrx, core, llc, cry};
  endfunction

  task automatic req(input rps_mode_e m);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_mode  <= m;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // cycles between two strobes; each strobe carries the bit offered the cycle before
  task automatic gap(input bit rx, output int g);
    int   s;
    logic bit_q;
    logic rdy_q;
    s = 0;
    g = 0;
    bit_q = 1'b0;
    rdy_q = 1'b0;
    for (int i = 0; i < 4 * RXD && s < 2; i++) begin
      bit_q = rx ? phy_rx_data : tx_bit;
      rdy_q = rx ? 1'b1 : tx_bit_ready;
      wait_cyc(1);
      if (s == 1) g++;
      if (rx ? ll_rx_strobe : phy_tx_strobe) begin
        s++;
        if (rx) begin
          chk("rx bit", {7'h0, bit_q}, {7'h0, ll_rx_data});
        end else begin
          chk("tx ready", 8'h01, {7'h0, rdy_q});
          chk("tx bit", {7'h0, bit_q}, {7'h0, phy_tx_data});
        end
      end
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_modes();
    wait_cyc(2);
    chk_mode(RPS_DSLEEP);
    chk("gates", 8'h20, gates());
    req(RPS_TX);
    chk_mode(RPS_DSLEEP);
    req(RPS_SLEEP);
    chk("gates", 8'h60, gates());
    req(RPS_TX);
    chk_mode(RPS_SLEEP);
    req(RPS_IDLE);
    chk("gates", 8'h67, gates());
  endtask

  task automatic t_stream();
    req(RPS_TX);
    chk("gates", 8'h77, gates());
    chk("crypto", 8'h01, {7'h0, cry});
    gap(1'b0, n);
    chk("tx gap", 8'(TXD), 8'(n));
    req(RPS_RX);
    chk_mode(RPS_TX);
    @(posedge sys_clk);
    busy_req <= 1'b1;
    req(RPS_IDLE);
    chk_mode(RPS_TX);
    @(posedge sys_clk);
    busy_req <= 1'b0;
    wait_cyc(3);
    chk_mode(RPS_IDLE);
    req(RPS_RX);
    chk("gates", 8'h6f, gates());
    gap(1'b1, n);
    chk("rx gap", 8'(RXD), 8'(n));
    req(RPS_DSLEEP);
    chk("gates", 8'h20, gates());
  endtask

  task automatic t_chip();
    @(posedge sys_clk);
    conn_req <= 3'h7;
    req(RPS_IDLE);
    chk("conn", 8'h04, {5'h0, conn_limit});
    @(posedge sys_clk);
    chip_mode <= 3'h4;
    wait_cyc(6);
    chk("retain", 8'h01, {7'h0, ret});
    req(RPS_SLEEP);
    chk_mode(RPS_IDLE);
    @(posedge sys_clk);
    chip_mode <= 3'h5;
    wait_cyc(6);
    chk_mode(RPS_OFF);
    chk("freeze", 8'h01, {7'h0, frz});
    @(posedge sys_clk);
    chip_mode <= 3'h3;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      wait_cyc(1);
      if (wrst === 1'b1) n++;
    end
    chk("wake", 8'h01, 8'(n));
    chk_mode(RPS_DSLEEP);
    req(RPS_IDLE);
    chk_mode(RPS_IDLE);
  endtask

  // reset in mid-run: everything off, then deep sleep with the watch crystal on
  task automatic t_reset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    wait_cyc(1);
    chk_mode(RPS_DSLEEP);
    chk("reset gates", 8'h00, gates());
    @(posedge sys_clk);
    arst_n <= 1'b1;
    wait_cyc(2);
    chk("gates", 8'h20, gates());
    req(RPS_IDLE);
    chk_mode(RPS_IDLE);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_modes();
    t_stream();
    t_chip();
    t_reset();
    results();
  end
endmodule
